// ### src/bpc_regs.sv
// Device-wide control register bank of a four-channel backplane transceiver.
// Assumes an AXI4-Lite master and byte-wide per-channel data in the aclk domain.
//
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module bpc_regs #(
	parameter int NUM_CH = bpc_pkg::BPC_NUM_CH
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write address and data
	input wire logic [bpc_pkg::BPC_ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read
	input wire logic [bpc_pkg::BPC_ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Per-channel receive data and aligner fill levels
	input wire bpc_pkg::bpc_bus_t rx_data,
	input wire bpc_pkg::bpc_fill_t aligner_fill,
	// Per-channel transmit data and framing byte slots
	input wire bpc_pkg::bpc_bus_t tx_data_in,
	input wire logic [bpc_pkg::BPC_NUM_CH-1:0] tx_first_slot,
	input wire logic [bpc_pkg::BPC_NUM_CH-1:0] tx_second_slot,
	output bpc_pkg::bpc_bus_t tx_data_out,
	// Parallel output ports
	output bpc_pkg::bpc_byte_t par_port_a,
	output bpc_pkg::bpc_byte_t par_port_c,
	// Aligner threshold violations
	output logic [bpc_pkg::BPC_NUM_CH-1:0] aligner_low_viol,
	output logic [bpc_pkg::BPC_NUM_CH-1:0] aligner_high_viol,
	// Static configuration to neighbouring logic
	output logic toh_port_a_sel,
	output logic toh_port_c_sel,
	output logic parity_odd,
	output logic scramble_en
);
	import bpc_pkg::*;

	// ****************************************
	// Elaboration checks
	// ****************************************
	// Refuse sizes that the fixed register layout cannot hold
	generate
		if (NUM_CH != BPC_NUM_CH) begin : g_bad_num_ch
			$error("bpc_regs serves exactly four channels");
		end
		if (BPC_IDX_W + 2 > BPC_ADDR_W) begin : g_bad_addr_w
			$error("bpc_regs register index does not fit the address");
		end
		if (BPC_TH_W > BPC_BYTE_W || BPC_CNT_W > BPC_BYTE_W) begin : g_bad_field_w
			$error("bpc_regs field wider than one register byte");
		end
		if (BPC_NUM_CH > BPC_BYTE_W) begin : g_bad_cmd_w
			$error("bpc_regs command bits exceed one register byte");
		end
		if (BPC_STAT_HIGH_LSB + BPC_NUM_CH > 32) begin : g_bad_status
			$error("bpc_regs status fields overflow the data word");
		end
	endgenerate

	// ****************************************
	// Register storage
	// ****************************************
	bpc_byte_t routing_ff;
	logic [BPC_TH_W-1:0] low_th_ff;
	logic [BPC_TH_W-1:0] high_th_ff;
	bpc_byte_t cnt_loop_ff;
	bpc_byte_t first_sub_ff;
	bpc_byte_t second_sub_ff;
	logic [BPC_NUM_CH-1:0] inj_cmd_ff;
	logic [BPC_NUM_CH-1:0] inj_busy;

	// ****************************************
	// AXI4-Lite write channel
	// ****************************************
	logic aw_full_ff;
	logic w_full_ff;
	logic [BPC_IDX_W-1:0] aw_idx_ff;
	bpc_byte_t w_byte_ff;
	logic w_lane0_ff;
	logic bvalid_ff;
	logic [1:0] bresp_ff;
	logic do_write;
	logic wr_hit;

	assign s_axi_awready = ~aw_full_ff;
	assign s_axi_wready = ~w_full_ff;
	assign do_write = aw_full_ff & w_full_ff & ~bvalid_ff;

	always_comb begin
		unique case (aw_idx_ff)
			BPC_IDX_ROUTING, BPC_IDX_LOW_TH, BPC_IDX_HIGH_TH, BPC_IDX_CNT_LOOP,
			BPC_IDX_FIRST_SUB, BPC_IDX_SECOND_SUB, BPC_IDX_INJ_CMD,
			BPC_IDX_STATUS: begin
				wr_hit = 1'b1;
			end
			default: begin
				wr_hit = 1'b0;
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_ff <= 1'b0;
			aw_idx_ff <= '0;
		end else if (s_axi_awvalid && !aw_full_ff) begin
			aw_full_ff <= 1'b1;
			aw_idx_ff <= s_axi_awaddr[BPC_IDX_W+1:2];
		end else if (do_write) begin
			aw_full_ff <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_full_ff <= 1'b0;
			w_byte_ff <= '0;
			w_lane0_ff <= 1'b0;
		end else if (s_axi_wvalid && !w_full_ff) begin
			w_full_ff <= 1'b1;
			w_byte_ff <= s_axi_wdata[BPC_BYTE_W-1:0];
			w_lane0_ff <= s_axi_wstrb[0];
		end else if (do_write) begin
			w_full_ff <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_ff <= 1'b0;
			bresp_ff <= BPC_RESP_OKAY;
		end else if (do_write) begin
			bvalid_ff <= 1'b1;
			bresp_ff <= wr_hit ? BPC_RESP_OKAY : BPC_RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_ff <= 1'b0;
		end
	end

	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp = bresp_ff;

	// ****************************************
	// Register writes
	// ****************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			routing_ff <= BPC_RST_ROUTING;
			low_th_ff <= BPC_RST_LOW_TH;
			high_th_ff <= BPC_RST_HIGH_TH;
			cnt_loop_ff <= BPC_RST_CNT_LOOP;
			first_sub_ff <= BPC_RST_SUB;
			second_sub_ff <= BPC_RST_SUB;
			inj_cmd_ff <= BPC_RST_INJ_CMD;
		end else if (do_write && w_lane0_ff) begin
			unique case (aw_idx_ff)
				BPC_IDX_ROUTING: routing_ff <= w_byte_ff;
				BPC_IDX_LOW_TH: low_th_ff <= w_byte_ff[BPC_TH_W-1:0];
				BPC_IDX_HIGH_TH: high_th_ff <= w_byte_ff[BPC_TH_W-1:0];
				BPC_IDX_CNT_LOOP: cnt_loop_ff <= w_byte_ff;
				BPC_IDX_FIRST_SUB: first_sub_ff <= w_byte_ff;
				BPC_IDX_SECOND_SUB: second_sub_ff <= w_byte_ff;
				BPC_IDX_INJ_CMD: inj_cmd_ff <= w_byte_ff[BPC_NUM_CH-1:0];
				default: begin
				end
			endcase
		end
	end

	// ****************************************
	// AXI4-Lite read channel
	// ****************************************
	logic rvalid_ff;
	logic [31:0] rdata_ff;
	logic [1:0] rresp_ff;
	logic [31:0] rd_word;
	logic rd_hit;
	logic [BPC_IDX_W-1:0] ar_idx;

	assign s_axi_arready = ~rvalid_ff;
	assign ar_idx = s_axi_araddr[BPC_IDX_W+1:2];

	always_comb begin
		rd_word = '0;
		rd_hit = 1'b1;
		unique case (ar_idx)
			BPC_IDX_ROUTING: rd_word[BPC_BYTE_W-1:0] = routing_ff;
			BPC_IDX_LOW_TH: rd_word[BPC_TH_W-1:0] = low_th_ff;
			BPC_IDX_HIGH_TH: rd_word[BPC_TH_W-1:0] = high_th_ff;
			BPC_IDX_CNT_LOOP: rd_word[BPC_BYTE_W-1:0] = cnt_loop_ff;
			BPC_IDX_FIRST_SUB: rd_word[BPC_BYTE_W-1:0] = first_sub_ff;
			BPC_IDX_SECOND_SUB: rd_word[BPC_BYTE_W-1:0] = second_sub_ff;
			BPC_IDX_INJ_CMD: rd_word[BPC_NUM_CH-1:0] = inj_cmd_ff;
			BPC_IDX_STATUS: begin
				rd_word[BPC_STAT_BUSY_LSB +: BPC_NUM_CH] = inj_busy;
				rd_word[BPC_STAT_LOW_LSB +: BPC_NUM_CH] = aligner_low_viol;
				rd_word[BPC_STAT_HIGH_LSB +: BPC_NUM_CH] = aligner_high_viol;
			end
			default: rd_hit = 1'b0;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_ff <= 1'b0;
			rdata_ff <= '0;
			rresp_ff <= BPC_RESP_OKAY;
		end else if (s_axi_arvalid && !rvalid_ff) begin
			rvalid_ff <= 1'b1;
			rdata_ff <= rd_word;
			rresp_ff <= rd_hit ? BPC_RESP_OKAY : BPC_RESP_SLVERR;
		end else if (s_axi_rready) begin
			rvalid_ff <= 1'b0;
		end
	end

	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rdata = rdata_ff;
	assign s_axi_rresp = rresp_ff;

	// ****************************************
	// Per-channel injection and aligner checks
	// ****************************************
	genvar ch;
	generate
		for (ch = 0; ch < BPC_NUM_CH; ch++) begin : g_ch
			bpc_inj_if inj_bus ();

			assign inj_bus.cmd = inj_cmd_ff[ch];
			assign inj_bus.count = cnt_loop_ff[BPC_CNT_W-1:0];
			assign inj_bus.first_val = first_sub_ff;
			assign inj_bus.second_val = second_sub_ff;
			assign inj_bus.first_slot = tx_first_slot[ch];
			assign inj_bus.second_slot = tx_second_slot[ch];
			// Loopback swaps the transmit source for the received byte
			assign inj_bus.data_in = cnt_loop_ff[BPC_BIT_LOOP] ? rx_data[ch] : tx_data_in[ch];
			assign tx_data_out[ch] = inj_bus.data_out;
			assign inj_busy[ch] = inj_bus.busy;

			bpc_inj u_inj (
				.aclk(aclk),
				.aresetn(aresetn),
				.p(inj_bus.inj)
			);

			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					aligner_low_viol[ch] <= 1'b0;
					aligner_high_viol[ch] <= 1'b0;
				end else begin
					aligner_low_viol[ch] <= (aligner_fill[ch] < low_th_ff);
					aligner_high_viol[ch] <= (aligner_fill[ch] > high_th_ff);
				end
			end
		end
	endgenerate

	// ****************************************
	// Parallel output port routing
	// ****************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			par_port_a <= '0;
			par_port_c <= '0;
		end else begin
			par_port_a <= routing_ff[BPC_BIT_PAR_A] ? rx_data[0] : rx_data[1];
			par_port_c <= routing_ff[BPC_BIT_PAR_C] ? rx_data[2] : rx_data[3];
		end
	end

	assign toh_port_a_sel = routing_ff[BPC_BIT_TOH_A];
	assign toh_port_c_sel = routing_ff[BPC_BIT_TOH_C];
	assign parity_odd = cnt_loop_ff[BPC_BIT_PARITY];
	assign scramble_en = cnt_loop_ff[BPC_BIT_SCRAMBLE];

endmodule : bpc_regs

// ### src/bpc_pkg.sv
// Constants and types for the backplane device control register bank.
// Assumes a 32-bit AXI4-Lite register bus; each register is one aligned word.
package bpc_pkg;

	// ****************************************
	// Geometry
	// ****************************************
	localparam int BPC_NUM_CH = 4;
	localparam int BPC_BYTE_W = 8;
	localparam int BPC_TH_W = 5;
	localparam int BPC_CNT_W = 4;
	localparam int BPC_ADDR_W = 8;
	localparam int BPC_IDX_W = 6;

	typedef logic [BPC_BYTE_W-1:0] bpc_byte_t;
	typedef logic [BPC_NUM_CH-1:0][BPC_BYTE_W-1:0] bpc_bus_t;
	typedef logic [BPC_NUM_CH-1:0][BPC_TH_W-1:0] bpc_fill_t;

	// ****************************************
	// Register indices; byte address is four times the index
	// ****************************************
	localparam logic [BPC_IDX_W-1:0] BPC_IDX_ROUTING = 6'h09;
	localparam logic [BPC_IDX_W-1:0] BPC_IDX_LOW_TH = 6'h0a;
	localparam logic [BPC_IDX_W-1:0] BPC_IDX_HIGH_TH = 6'h0b;
	localparam logic [BPC_IDX_W-1:0] BPC_IDX_CNT_LOOP = 6'h0c;
	localparam logic [BPC_IDX_W-1:0] BPC_IDX_FIRST_SUB = 6'h0d;
	localparam logic [BPC_IDX_W-1:0] BPC_IDX_SECOND_SUB = 6'h0e;
	localparam logic [BPC_IDX_W-1:0] BPC_IDX_INJ_CMD = 6'h1c;
	localparam logic [BPC_IDX_W-1:0] BPC_IDX_STATUS = 6'h1d;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int BPC_BIT_TOH_A = 0;
	localparam int BPC_BIT_TOH_C = 1;
	localparam int BPC_BIT_PAR_A = 2;
	localparam int BPC_BIT_PAR_C = 3;
	localparam int BPC_BIT_LOOP = 4;
	localparam int BPC_BIT_PARITY = 5;
	localparam int BPC_BIT_SCRAMBLE = 6;
	localparam int BPC_STAT_BUSY_LSB = 0;
	localparam int BPC_STAT_LOW_LSB = 4;
	localparam int BPC_STAT_HIGH_LSB = 8;

	// ****************************************
	// Reset values
	// ****************************************
	localparam bpc_byte_t BPC_RST_ROUTING = 8'h0f;
	localparam logic [BPC_TH_W-1:0] BPC_RST_LOW_TH = 5'h02;
	localparam logic [BPC_TH_W-1:0] BPC_RST_HIGH_TH = 5'h15;
	localparam bpc_byte_t BPC_RST_CNT_LOOP = 8'h40;
	localparam bpc_byte_t BPC_RST_SUB = 8'h00;
	localparam logic [BPC_NUM_CH-1:0] BPC_RST_INJ_CMD = 4'h0;

	// ****************************************
	// AXI responses
	// ****************************************
	localparam logic [1:0] BPC_RESP_OKAY = 2'h0;
	localparam logic [1:0] BPC_RESP_SLVERR = 2'h2;

endpackage : bpc_pkg

// ### src/bpc_inj_if.sv
// Bundle between the register bank and one channel's framing error injector.
// Assumes the package bpc_pkg is compiled first.
`timescale 1ns/1ps
interface bpc_inj_if;
	import bpc_pkg::*;

	logic cmd;
	logic [BPC_CNT_W-1:0] count;
	bpc_byte_t first_val;
	bpc_byte_t second_val;
	logic first_slot;
	logic second_slot;
	bpc_byte_t data_in;
	bpc_byte_t data_out;
	logic busy;

	modport ctl (
		output cmd, count, first_val, second_val, first_slot, second_slot, data_in,
		input data_out, busy
	);
	modport inj (
		input cmd, count, first_val, second_val, first_slot, second_slot, data_in,
		output data_out, busy
	);

endinterface : bpc_inj_if

// ### src/bpc_inj.sv
// One channel's transmit framing byte error injector.
// Assumes slot strobes mark the first and second framing bytes of each frame.
`timescale 1ns/1ps
module bpc_inj (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Register side and data path
	bpc_inj_if.inj p
);
	import bpc_pkg::*;

	logic cmd_ff;
	logic [BPC_CNT_W-1:0] left_ff;
	logic mid_frame_ff;
	bpc_byte_t data_ff;
	logic rise;

	// Edge detection is private to this channel instance
	assign rise = p.cmd & ~cmd_ff;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cmd_ff <= 1'b0;
		end else begin
			cmd_ff <= p.cmd;
		end
	end

	// Frames still to corrupt; a new edge reloads the count
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			left_ff <= '0;
		end else if (rise) begin
			left_ff <= p.count;
		end else if (p.second_slot && mid_frame_ff && left_ff != '0) begin
			left_ff <= left_ff - 1'b1;
		end
	end

	// A frame is corrupted only from its first framing byte on
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mid_frame_ff <= 1'b0;
		end else if (rise || p.second_slot) begin
			mid_frame_ff <= 1'b0;
		end else if (p.first_slot && left_ff != '0) begin
			mid_frame_ff <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			data_ff <= '0;
		end else if (!rise && p.first_slot && left_ff != '0) begin
			data_ff <= p.first_val;
		end else if (!rise && p.second_slot && mid_frame_ff) begin
			data_ff <= p.second_val;
		end else begin
			data_ff <= p.data_in;
		end
	end

	assign p.data_out = data_ff;
	assign p.busy = (left_ff != '0);

endmodule : bpc_inj

// ### src/bpc_regs_note_unused.sv
`timescale 1ns/1ps

// ### dv/bpc_regs_chk.sv
// Port checker for the backplane control register bank.
// Assumes the bench keeps the low fill threshold below the high one.
`timescale 1ns/1ps
module bpc_regs_chk #(
	parameter int NUM_CH = 4
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Register bus
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	// Data paths
	input wire bpc_pkg::bpc_bus_t rx_data,
	input wire bpc_pkg::bpc_bus_t tx_data_in,
	input wire logic [3:0] tx_first_slot,
	input wire logic [3:0] tx_second_slot,
	input wire bpc_pkg::bpc_bus_t tx_data_out,
	input wire bpc_pkg::bpc_byte_t par_port_a,
	input wire bpc_pkg::bpc_byte_t par_port_c,
	input wire logic [3:0] aligner_low_viol,
	input wire logic [3:0] aligner_high_viol
);
	import bpc_pkg::*;
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_rd_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	a_port_a_route: assert property ($past(aresetn) |->
		par_port_a == $past(rx_data[0]) || par_port_a == $past(rx_data[1]))
		else $error("port A carries neither A nor B");
	a_port_c_route: assert property ($past(aresetn) |->
		par_port_c == $past(rx_data[2]) || par_port_c == $past(rx_data[3]))
		else $error("port C carries neither C nor D");
	a_tx_plain_pass: assert property ($past(aresetn) && !$past(tx_first_slot[0]) &&
		!$past(tx_second_slot[0]) |->
		tx_data_out[0] == $past(tx_data_in[0]) || tx_data_out[0] == $past(rx_data[0]))
		else $error("non-framing byte altered");
	a_viol_excl: assert property ((aligner_low_viol & aligner_high_viol) == 4'h0)
		else $error("low and high violation together");
	a_write_resp: assert property (s_wr_taken |-> ##[1:2] s_axi_bvalid)
		else $error("write response late");
	a_read_resp: assert property (s_rd_taken |=> s_axi_rvalid)
		else $error("read data late");
	a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped");
	a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
	a_ar_blocked: assert property (s_rd_taken |=> !s_axi_arready)
		else $error("address taken during read data");
endmodule : bpc_regs_chk

bind bpc_regs bpc_regs_chk #(.NUM_CH(NUM_CH)) u_bpc_regs_chk (.*);

// ### dv/bpc_fabric.sv
// Fabric model: frames every 32 cycles, data that changes every cycle.
// Assumes frames are enabled only while run is high.
`timescale 1ns/1ps
module bpc_fabric (
	// Clock and frame enable
	input wire logic aclk,
	input wire logic run,
	// Fabric side of the bank
	output bpc_pkg::bpc_bus_t rx_data,
	output bpc_pkg::bpc_fill_t aligner_fill,
	output bpc_pkg::bpc_bus_t tx_data_in,
	output logic [3:0] tx_first_slot,
	output logic [3:0] tx_second_slot
);
	import bpc_pkg::*;
	logic [4:0] ph_ff = 5'h00;
	always @(posedge aclk) ph_ff <= ph_ff + 5'h01;
	always_comb begin
		for (int c = 0; c < 4; c++) begin
			rx_data[c] = {2'(c), 1'b1, ph_ff};
			tx_data_in[c] = {2'(c), 1'b0, ph_ff};
			aligner_fill[c] = ph_ff + 5'(c * 7);
			tx_first_slot[c] = run && ph_ff == 5'h03;
			tx_second_slot[c] = run && ph_ff == 5'h04;
		end
	end
endmodule : bpc_fabric

// ### dv/tb.sv
// Self-checking bench for the control register bank over AXI4-Lite.
// Assumes the fabric model and the checker are compiled with it.
`timescale 1ns/1ps
module tb;
	import bpc_pkg::*;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic run = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	bpc_bus_t rx_data, tx_data_in, tx_data_out, p_rx, ex;
	bpc_fill_t aligner_fill, p_fill;
	logic [3:0] tx_first_slot, tx_second_slot, aligner_low_viol, aligner_high_viol;
	logic [3:0] on = 4'h0;
	logic [3:0] rem [4] = '{default: 4'h0};
	bpc_byte_t par_port_a, par_port_c;
	bpc_byte_t rsel = 8'h0f, sub1 = 8'h00, sub2 = 8'h00, cl = 8'h40;
	logic [4:0] lo = 5'h02, hi = 5'h15;
	logic toh_port_a_sel, toh_port_c_sel, parity_odd, scramble_en;
	logic mon = 1'b0, loop = 1'b0;
	logic [7:0] rst [6] = '{8'h0f, 8'h02, 8'h15, 8'h40, 8'h00, 8'h00};
	int errors = 0, checks = 0, cyc = 0;

	bpc_regs u_bpc_regs (.*);
	bpc_fabric u_bpc_fabric (.*);

	always #4 aclk = ~aclk;

	// ****************************************
	// Reporting and bus tasks
	// ****************************************
	task automatic summarize;
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : summarize

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		forever begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) break;
		end
		s_axi_bready <= 1'b0;
		chk(32'(s_axi_bresp), 32'(er));
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] ev, input logic [1:0] er);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		forever begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) break;
		end
		s_axi_rready <= 1'b0;
		chk(s_axi_rdata, ev);
		chk(32'(s_axi_rresp), 32'(er));
	endtask : rd

	task automatic watch(input int n);
		mon = 1'b1;
		repeat (n) @(posedge aclk);
		mon = 1'b0;
	endtask : watch

	// ****************************************
	// Expected data path and port monitor
	// ****************************************
	always @(posedge aclk) begin
		p_rx <= rx_data;
		p_fill <= aligner_fill;
		for (int c = 0; c < 4; c++) begin
			ex[c] <= loop ? rx_data[c] : tx_data_in[c];
			if (tx_first_slot[c] && rem[c] != 4'h0) begin
				ex[c] <= sub1;
				on[c] = 1'b1;
			end else if (tx_second_slot[c] && on[c]) begin
				ex[c] <= sub2;
				on[c] = 1'b0;
				rem[c] = rem[c] - 4'h1;
			end
		end
	end

	always @(negedge aclk) begin
		if (mon) begin
			chk(32'(par_port_a), 32'(rsel[2] ? p_rx[0] : p_rx[1]));
			chk(32'(par_port_c), 32'(rsel[3] ? p_rx[2] : p_rx[3]));
			chk(32'({toh_port_a_sel, toh_port_c_sel, parity_odd, scramble_en}),
				32'({rsel[0], rsel[1], cl[5], cl[6]}));
			chk(32'(tx_data_out), 32'(ex));
			for (int c = 0; c < 4; c++) begin
				chk(32'({aligner_low_viol[c], aligner_high_viol[c]}),
					32'({p_fill[c] < lo, p_fill[c] > hi}));
			end
		end
	end

	always @(posedge aclk) begin
		cyc++;
		if (cyc == 2000) begin
			errors++;
			summarize();
		end
	end

	// ****************************************
	// Test sequence
	// ****************************************
	initial begin
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		for (int i = 0; i < 6; i++) begin
			rd(8'h24 + 8'(4 * i), {24'h0, rst[i]}, 2'h0);
		end
		chk(32'({toh_port_a_sel, toh_port_c_sel, parity_odd, scramble_en}),
			32'h0000000d);
		rd(8'h7c, 32'h0, 2'h2);
		wr(8'h7c, 8'h55, 2'h2);
		for (int i = 0; i < 4; i++) begin
			rsel = 8'(i << 2);
			wr(8'h24, rsel, 2'h0);
			watch(4);
		end
		lo = 5'h05;
		hi = 5'h10;
		wr(8'h28, 8'h05, 2'h0);
		wr(8'h2c, 8'h10, 2'h0);
		watch(40);
		sub1 = 8'hf6;
		sub2 = 8'h28;
		cl = 8'h02;
		wr(8'h30, cl, 2'h0);
		wr(8'h34, sub1, 2'h0);
		wr(8'h38, sub2, 2'h0);
		s_axi_wstrb <= 4'he;
		wr(8'h38, 8'h11, 2'h0);
		s_axi_wstrb <= 4'hf;
		rd(8'h38, {24'h0, sub2}, 2'h0);
		for (int i = 0; i < 2; i++) begin
			wr(8'h70, i ? 8'h03 : 8'h01, 2'h0);
			rem[i] = 4'h2;
			run <= 1'b1;
			watch(104);
			run <= 1'b0;
			repeat (8) @(posedge aclk);
		end
		rd(8'h70, 32'h3, 2'h0);
		loop = 1'b1;
		cl = 8'h10;
		wr(8'h30, cl, 2'h0);
		watch(40);
		summarize();
	end
endmodule : tb
